// ==== hdl/sacc_pkg.sv ====
package sacc_pkg;
    // Register byte addresses on the APB
    localparam logic [7:0] ADDR_CTRL_CHAN   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_FMT    = 8'h04;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
    localparam logic [7:0] ADDR_RESULT_LOW  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ         = 8'h10;
    localparam logic [7:0] ADDR_SYS         = 8'h14;
    // Field positions, first control register
    localparam int POS_ENABLE  = 0;
    localparam int POS_GO      = 1;
    localparam int POS_CHAN_LO = 2;
    // Field positions, second control register
    localparam int POS_REF_LO  = 0;
    localparam int POS_CLK_LO  = 4;
    localparam int POS_JUSTIFY = 7;
    // Field positions, interrupt register and system register
    localparam int POS_IRQ_FLAG   = 0;
    localparam int POS_IRQ_ENABLE = 1;
    localparam int POS_SLEEP      = 0;
    // Reset values
    localparam logic [7:0] RST_CTRL_CHAN = 8'h00;
    localparam logic [7:0] RST_CTRL_FMT  = 8'h00;
    // Clock select codes
    localparam logic [2:0] CLK_DIV2  = 3'h0;
    localparam logic [2:0] CLK_DIV8  = 3'h1;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_DIV4  = 3'h4;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    // Channel codes
    localparam logic [4:0] CHAN_LAST_PIN = 5'h1B;
    localparam logic [4:0] CHAN_TEMP     = 5'h1E;
    localparam logic [4:0] CHAN_FIXED    = 5'h1F;
    // Conversion timing in bit periods, counted in half periods
    localparam int          RESOLUTION   = 10;
    localparam logic [4:0]  CONV_HALVES  = 5'h17;  // 11.5 periods
    localparam logic [4:0]  FIRST_DECIDE = 5'h03;  // Half period of first bit
    // Extra instruction cycle before an RC-clocked start
    localparam int          INSTR_NS     = 200;
    localparam int          CLK_NS       = 40;
    localparam logic [7:0]  RC_DELAY_CYC =
        8'((INSTR_NS + CLK_NS - 1) / CLK_NS);
    // Sequencer request to the converter core
    typedef struct packed {
        logic       powered;   // Core supplied with operating current
        logic       sample;    // Sample-and-hold tracking input
        logic       decide;    // One-cycle bit-decision strobe
        logic [3:0] bit_index; // Bit under trial
        logic [9:0] trial;     // Trial code for the DAC
    } sacc_core_req_s;
endpackage : sacc_pkg

// ==== hdl/sacc_tick_gen.sv ====
// Half-period strobes of the bit conversion period
module sacc_tick_gen
    import sacc_pkg::*;
(
    input  wire logic       ref_clk,     // System clock
    input  wire logic       rst,         // Synchronous reset
    input  wire logic       run,         // Count while high
    input  wire logic [2:0] clk_sel,     // Conversion clock select
    input  wire logic       rc_clk_pin,  // Dedicated RC oscillator
    output logic            half_tick    // Half-period strobe
);
    logic [4:0] div_cnt;
    logic [4:0] next_div_cnt;
    logic [2:0] rc_sync;
    logic [2:0] next_rc_sync;
    logic       next_half_tick;
    logic [4:0] div_top;

    // Half-period length minus one, in system clocks, per select
    function automatic logic [4:0] half_len(input logic [2:0] sel);
        case (sel)
            CLK_DIV2:  half_len = 5'h00;
            CLK_DIV4:  half_len = 5'h01;
            CLK_DIV8:  half_len = 5'h03;
            CLK_DIV16: half_len = 5'h07;
            CLK_DIV32: half_len = 5'h0F;
            CLK_DIV64: half_len = 5'h1F;
            default:   half_len = 5'h00;
        endcase
    endfunction : half_len

    // Divider or RC edge detector on the synchronised oscillator
    always_comb begin
        div_top        = half_len(clk_sel);
        next_rc_sync   = {rc_sync[1:0], rc_clk_pin};
        next_div_cnt   = div_cnt;
        next_half_tick = 1'b0;
        if (!run) begin
            next_div_cnt = 5'h00;
        end else if (clk_sel[1:0] == 2'b11) begin
            next_half_tick = rc_sync[2] ^ rc_sync[1];
        end else if (div_cnt >= div_top) begin
            next_div_cnt   = 5'h00;
            next_half_tick = 1'b1;
        end else begin
            next_div_cnt = div_cnt + 5'h01;
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt   <= 5'h00;
            rc_sync   <= 3'h0;
            half_tick <= 1'b0;
        end else begin
            div_cnt   <= next_div_cnt;
            rc_sync   <= next_rc_sync;
            half_tick <= next_half_tick;
        end
    end
endmodule : sacc_tick_gen

// ==== hdl/sacc_top.sv ====
// Behaviour
// - Completion flag sets after every conversion, irrespective of irq enable.
// - Completion flag holds until software clears it.
// - In sleep with irq enabled, completion raises irq and wake.
// - Enable bit powers converter; writing go bit starts conversion.
// - Completion clears go, sets flag, loads both result registers.
// - Clearing go aborts; undecided bits copy the last decided bit.
// - Reset restores registers, powers off, ends any conversion.
// - RC clock start waits one extra instruction cycle.
// - Sleep, RC clock, irq off: power down after completion.
// - Non-RC clock, entering sleep aborts and powers down.
// - Compare trigger sets go and resets its timer.
// - Right justify: high register upper six bits zero.
// - Left justify: low register lower six bits zero.
// - Clock select picks system divide or RC clock.
// - Channel select routes inputs, temperature, fixed reference, none.
// - Reference select: supply, external pin, fixed reference.
// - Enable bit low keeps converter unpowered.
// - Unimplemented control bits read zero; control resets to zero.
// - Conversion takes 11.5 bit periods.
// - Left justify places bits 9..2 high, 1..0 low top.
//
// Added by the designer: the APB slave port and the address map.
module sacc_top
    import sacc_pkg::*;
(
    input  wire logic        ref_clk,       // 25 MHz system clock
    input  wire logic        rst,           // Synchronous reset
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic [31:0]      prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic        rc_clk_pin,    // Dedicated RC oscillator
    input  wire logic        special_trig,  // Compare trigger pulse
    input  wire logic        comp_pin,      // Comparator from core
    output sacc_core_req_s   core_req,      // Request to converter core
    output logic [4:0]       input_channel_sel, // Mux channel code
    output logic             chan_connected,    // Mux path closed
    output logic [1:0]       pos_ref_sel,       // Positive reference
    output logic             timer_reset,   // Reset of trigger timer
    output logic             conv_irq,      // Completion interrupt
    output logic             wake_req       // Sleep wake request
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_OFF   = 4'b1000
    } sacc_state_e;

    // Control state and its next values
    logic [7:0]  ctrl_chan;
    logic [7:0]  ctrl_fmt;
    logic [7:0]  result_high;
    logic [7:0]  result_low;
    logic        conv_done_flag;
    logic        conv_irq_enable;
    logic        sleep_mode;
    logic [7:0]  next_ctrl_chan;
    logic [7:0]  next_ctrl_fmt;
    logic [7:0]  next_result_high;
    logic [7:0]  next_result_low;
    logic        next_conv_done_flag;
    logic        next_conv_irq_enable;
    logic        next_sleep_mode;
    // Sequencer state
    sacc_state_e state;
    sacc_state_e next_state;
    logic [4:0]  halves;
    logic [4:0]  next_halves;
    logic [7:0]  delay_cnt;
    logic [7:0]  next_delay_cnt;
    logic [9:0]  sar;
    logic [9:0]  next_sar;
    logic [3:0]  bit_idx;
    logic [3:0]  next_bit_idx;
    logic [1:0]  comp_sync;
    logic [1:0]  trig_sync;
    logic        trig_prev;
    // Outputs and their next values
    logic [31:0]    next_prdata;
    logic           next_pready;
    logic           next_pslverr;
    sacc_core_req_s next_core_req;
    logic           next_chan_connected;
    logic           next_timer_reset;
    logic           next_conv_irq;
    logic           next_wake_req;
    // Internal decode
    logic        half_tick;
    logic        bus_wr;
    logic        bus_rd;
    logic        is_rc;
    logic        finish;
    logic [9:0]  loaded;
    logic        trig_rise;

    // Conversion clock strobes
    sacc_tick_gen u_tick (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .run        (state == ST_CONV),
        .clk_sel    (ctrl_fmt[POS_CLK_LO +: 3]),
        .rc_clk_pin (rc_clk_pin),
        .half_tick  (half_tick)
    );

    // Fill undecided bits with the last decided one
    function automatic logic [9:0] fill_partial(input logic [9:0] v,
                                                input logic [3:0] idx);
        logic [9:0] r;
        r = v;
        for (int i = 0; i < RESOLUTION; i++) begin
            if (i <= int'(idx) && int'(idx) < RESOLUTION - 1) begin
                r[i] = v[idx + 4'h1];
            end
        end
        fill_partial = r;
    endfunction : fill_partial

    // APB handshake: one wait state before ready in each access phase
    always_comb begin
        bus_wr    = psel && penable && pwrite && !pready;
        bus_rd    = psel && penable && !pwrite && !pready;
        is_rc     = ctrl_fmt[POS_CLK_LO + 1 +: 2] == 2'b11
                    || ctrl_fmt[POS_CLK_LO +: 2] == 2'b11;
        is_rc     = ctrl_fmt[POS_CLK_LO +: 2] == 2'b11;
        trig_rise = trig_sync[1] && !trig_prev;
    end

    // Sequencer and register next values
    always_comb begin
        next_ctrl_chan       = ctrl_chan;
        next_ctrl_fmt        = ctrl_fmt;
        next_result_high     = result_high;
        next_result_low      = result_low;
        next_conv_done_flag  = conv_done_flag;
        next_conv_irq_enable = conv_irq_enable;
        next_sleep_mode      = sleep_mode;
        next_state           = state;
        next_halves          = halves;
        next_delay_cnt       = delay_cnt;
        next_sar             = sar;
        next_bit_idx         = bit_idx;
        next_timer_reset     = 1'b0;
        finish               = 1'b0;
        loaded               = sar;
        // Register writes
        if (bus_wr) begin
            case (paddr)
                ADDR_CTRL_CHAN: next_ctrl_chan = {1'b0, pwdata[6:0]};
                ADDR_CTRL_FMT:  next_ctrl_fmt  =
                    {pwdata[7:4], 2'b00, pwdata[1:0]};
                ADDR_RESULT_HIGH: next_result_high = pwdata[7:0];
                ADDR_RESULT_LOW:  next_result_low  = pwdata[7:0];
                ADDR_IRQ: begin
                    next_conv_done_flag  = pwdata[POS_IRQ_FLAG];
                    next_conv_irq_enable = pwdata[POS_IRQ_ENABLE];
                end
                ADDR_SYS: next_sleep_mode = pwdata[POS_SLEEP];
                default: ;
            endcase
        end
        // Hardware start from the compare trigger
        if (trig_rise) begin
            next_ctrl_chan[POS_GO] = 1'b1;
            next_timer_reset       = 1'b1;
        end
        // Disabled module: go cannot be set
        if (!next_ctrl_chan[POS_ENABLE]) begin
            next_ctrl_chan[POS_GO] = 1'b0;
        end
        case (state)
            ST_IDLE: begin
                if (next_ctrl_chan[POS_GO] && !ctrl_chan[POS_GO]) begin
                    next_sar       = 10'h000;
                    next_bit_idx   = 4'h9;
                    next_halves    = 5'h00;
                    next_delay_cnt = RC_DELAY_CYC;
                    next_state     = is_rc ? ST_DELAY : ST_CONV;
                end
            end
            ST_DELAY: begin
                next_delay_cnt = delay_cnt - 8'h01;
                if (delay_cnt == 8'h01) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (half_tick) begin
                    next_halves = halves + 5'h01;
                    // Decide a bit every second half period
                    if (halves >= FIRST_DECIDE && halves[0]
                            && bit_idx < 4'hA) begin
                        next_sar[bit_idx] = comp_sync[1];
                        next_bit_idx      = bit_idx - 4'h1;
                    end
                    if (halves == CONV_HALVES - 5'h01) begin
                        finish = 1'b1;
                    end
                end
            end
            ST_OFF: begin
                if (!sleep_mode || !ctrl_chan[POS_ENABLE]) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Abort by software clear, sleep without RC, or disable
        if (state == ST_CONV || state == ST_DELAY) begin
            if (sleep_mode && !is_rc) begin
                next_ctrl_chan[POS_GO] = 1'b0;
                next_state             = ST_OFF;
            end else if (!next_ctrl_chan[POS_GO] && !finish) begin
                next_state = ST_IDLE;
                if (state == ST_CONV) begin
                    finish = 1'b1;
                    loaded = fill_partial(sar, bit_idx);
                end
            end
        end
        // Completion: clear go, set flag, load result
        if (finish) begin
            if (state == ST_CONV && next_ctrl_chan[POS_GO]) begin
                loaded = next_sar;
            end
            next_ctrl_chan[POS_GO] = 1'b0;
            next_conv_done_flag    = 1'b1;
            if (ctrl_fmt[POS_JUSTIFY]) begin
                next_result_high = {6'h00, loaded[9:8]};
                next_result_low  = loaded[7:0];
            end else begin
                next_result_high = loaded[9:2];
                next_result_low  = {loaded[1:0], 6'h00};
            end
            next_state = (sleep_mode && is_rc && !conv_irq_enable)
                       ? ST_OFF : ST_IDLE;
        end
        if (!next_ctrl_chan[POS_ENABLE]) begin
            next_state = ST_IDLE;
        end
    end

    // Output next values
    always_comb begin
        next_prdata  = prdata;
        next_pready  = psel && penable && !pready;
        next_pslverr = 1'b0;
        if (bus_rd || bus_wr) begin
            next_prdata = 32'h0000_0000;
            case (paddr)
                ADDR_CTRL_CHAN:   next_prdata[7:0] = ctrl_chan;
                ADDR_CTRL_FMT:    next_prdata[7:0] = ctrl_fmt;
                ADDR_RESULT_HIGH: next_prdata[7:0] = result_high;
                ADDR_RESULT_LOW:  next_prdata[7:0] = result_low;
                ADDR_IRQ: next_prdata[1:0] = {conv_irq_enable, conv_done_flag};
                ADDR_SYS:         next_prdata[0]   = sleep_mode;
                default:          next_pslverr     = 1'b1;
            endcase
            if (bus_wr) begin
                next_prdata = 32'h0000_0000;
            end
        end
        next_core_req.powered   = next_ctrl_chan[POS_ENABLE]
                                  && next_state != ST_OFF;
        next_core_req.sample    = next_core_req.powered
                                  && next_state == ST_IDLE;
        next_core_req.decide    = next_state == ST_CONV && half_tick
                                  && halves >= FIRST_DECIDE && halves[0]
                                  && bit_idx < 4'hA;
        next_core_req.bit_index = next_bit_idx;
        next_core_req.trial     = next_sar
                                  | ((next_bit_idx < 4'hA)
                                     ? (10'h001 << next_bit_idx) : 10'h000);
        next_chan_connected = next_ctrl_chan[POS_CHAN_LO +: 5] <= CHAN_LAST_PIN
            || next_ctrl_chan[POS_CHAN_LO +: 5] >= CHAN_TEMP;
        next_conv_irq  = next_conv_done_flag && next_conv_irq_enable;
        next_wake_req  = next_conv_irq && next_sleep_mode;
    end

    // Registers, all reset; state to ST_IDLE, the rest cleared
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_chan         <= RST_CTRL_CHAN;
            ctrl_fmt          <= RST_CTRL_FMT;
            result_high       <= 8'h00;
            result_low        <= 8'h00;
            conv_done_flag    <= 1'b0;
            conv_irq_enable   <= 1'b0;
            sleep_mode        <= 1'b0;
            state             <= ST_IDLE;
            halves            <= 5'h00;
            delay_cnt         <= 8'h00;
            sar               <= 10'h000;
            bit_idx           <= 4'h0;
            comp_sync         <= 2'h0;
            trig_sync         <= 2'h0;
            trig_prev         <= 1'b0;
            prdata            <= 32'h0000_0000;
            pready            <= 1'b0;
            pslverr           <= 1'b0;
            core_req          <= '0;
            input_channel_sel <= 5'h00;
            chan_connected    <= 1'b0;
            pos_ref_sel       <= 2'h0;
            timer_reset       <= 1'b0;
            conv_irq          <= 1'b0;
            wake_req          <= 1'b0;
        end else begin
            ctrl_chan         <= next_ctrl_chan;
            ctrl_fmt          <= next_ctrl_fmt;
            result_high       <= next_result_high;
            result_low        <= next_result_low;
            conv_done_flag    <= next_conv_done_flag;
            conv_irq_enable   <= next_conv_irq_enable;
            sleep_mode        <= next_sleep_mode;
            state             <= next_state;
            halves            <= next_halves;
            delay_cnt         <= next_delay_cnt;
            sar               <= next_sar;
            bit_idx           <= next_bit_idx;
            comp_sync         <= {comp_sync[0], comp_pin};
            trig_sync         <= {trig_sync[0], special_trig};
            trig_prev         <= trig_sync[1];
            prdata            <= next_prdata;
            pready            <= next_pready;
            pslverr           <= next_pslverr;
            core_req          <= next_core_req;
            input_channel_sel <= next_ctrl_chan[POS_CHAN_LO +: 5];
            chan_connected    <= next_chan_connected;
            pos_ref_sel       <= next_ctrl_fmt[POS_REF_LO +: 2];
            timer_reset       <= next_timer_reset;
            conv_irq          <= next_conv_irq;
            wake_req          <= next_wake_req;
        end
    end
endmodule : sacc_top

// ==== verif/sacc_core_model.sv ====
// Converter core stand-in: comparator against a held input level
module sacc_core_model
    import sacc_pkg::*;
(
    input  wire logic           ref_clk,  // System clock
    input  wire sacc_core_req_s core_req, // Sequencer request
    input  wire logic [9:0]     level,    // Held input level
    output logic                comp_pin  // Comparator result
);
    timeunit 1ns;
    timeprecision 1ns;
    initial comp_pin = 1'b0;
    // Trial at or below the level keeps the bit; unpowered output wanders
    always @(posedge ref_clk) begin
        if (core_req.powered) comp_pin <= (core_req.trial <= level);
        else comp_pin <= ~comp_pin;
    end
endmodule : sacc_core_model

// ==== verif/sacc_checker.sv ====
module sacc_checker
    import sacc_pkg::*;
(
    input wire logic           ref_clk,           // System clock
    input wire logic           rst,               // Synchronous reset
    input wire logic           pwrite,            // APB direction
    input wire logic [31:0]    prdata,            // APB read data
    input wire logic           pready,            // APB ready
    input wire logic           pslverr,           // APB error
    input wire logic           special_trig,      // Compare trigger
    input wire sacc_core_req_s core_req,          // Core request
    input wire logic [4:0]     input_channel_sel, // Channel code
    input wire logic           chan_connected,    // Path closed
    input wire logic           timer_reset,       // Timer reset pulse
    input wire logic           conv_irq,          // Interrupt
    input wire logic           wake_req           // Wake request
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("ready held over one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_READ_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_DECIDE_ONE: assert property (core_req.decide |=> !core_req.decide)
        else $error("decide strobe too long");
    AST_DECIDE_POWER: assert property (core_req.decide |-> core_req.powered)
        else $error("decision while unpowered");
    AST_NO_PATH: assert property (input_channel_sel inside {5'h1C, 5'h1D} |-> !chan_connected)
        else $error("empty channel connected");
    AST_TRIG_TIMER: assert property ($rose(special_trig) |-> ##[1:6] timer_reset)
        else $error("trigger gave no timer reset");
    AST_WAKE_IRQ: assert property (wake_req |-> conv_irq)
        else $error("wake without interrupt");
    AST_RESET_OFF: assert property ($fell(rst) |-> !core_req.powered && !conv_irq)
        else $error("active after reset");
    AST_IRQ_HOLD: assert property ($fell(conv_irq) |-> pready)
        else $error("interrupt dropped without access");
endmodule : sacc_checker

bind sacc_top sacc_checker u_chk (.ref_clk(ref_clk), .rst(rst),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .special_trig(special_trig), .core_req(core_req),
    .input_channel_sel(input_channel_sel), .chan_connected(chan_connected),
    .timer_reset(timer_reset), .conv_irq(conv_irq), .wake_req(wake_req));

// ==== verif/tb_top.sv ====
module tb_top;
    import sacc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [31:0] val;  // Expected read data
        logic        err;  // Expected error
    } sacc_note_s;
    logic           ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic           pwrite = 1'b0, rc_clk_pin = 1'b0, special_trig = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0, prdata;
    logic           pready, pslverr, comp_pin, chan_connected;
    logic           timer_reset, conv_irq, wake_req;
    logic [4:0]     input_channel_sel;
    logic [1:0]     pos_ref_sel;
    logic [9:0]     level = 10'h0;
    sacc_core_req_s core_req;
    int             err_total = 0, n_checks = 0, cyc = 0, seed = 32'h9F7DA1DE;
    int             hv [8] = '{1, 4, 16, 0, 2, 8, 32, 0};
    sacc_note_s     notes [$];
    // System clock and a free-running RC oscillator of unrelated phase
    always #20 ref_clk = ~ref_clk;
    always #307 rc_clk_pin = ~rc_clk_pin;
    sacc_top DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rc_clk_pin(rc_clk_pin), .special_trig(special_trig),
        .comp_pin(comp_pin), .core_req(core_req),
        .input_channel_sel(input_channel_sel),
        .chan_connected(chan_connected), .pos_ref_sel(pos_ref_sel),
        .timer_reset(timer_reset), .conv_irq(conv_irq), .wake_req(wake_req));
    sacc_core_model u_core (.ref_clk(ref_clk), .core_req(core_req),
        .level(level), .comp_pin(comp_pin));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // APB transfer: note the expectation, hold until ready, then release
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input sacc_note_s nt);
        int n = 0;
        notes.push_back(nt);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_total++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, {32'h0, 1'b0});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        apb(1'b0, a, 32'h0, {24'h0, v, 1'b0});
    endtask : rd
    // Wait for the interrupt, or for the core to power down
    task automatic wait_end(input logic on_irq, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((on_irq ? conv_irq !== 1'b1 : core_req.powered !== 1'b0)
                   && n < 4000);
    endtask : wait_end
    // Each completed transfer is matched against the oldest note
    always @(posedge ref_clk) begin : watch
        sacc_note_s nt;
        if (pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            chk(prdata, nt.val);
            chk(pslverr, nt.err);
        end
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            end_of_test();
        end
    end
    // Main sequence
    initial begin : main
        int n;
        logic fm;
        logic [1:0] rf;
        logic [4:0] ch;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(ADDR_CTRL_CHAN, 8'h00);
        rd(ADDR_CTRL_FMT, 8'h00);
        wr(ADDR_CTRL_FMT, 8'hFF);
        rd(ADDR_CTRL_FMT, 8'hF3);
        wr(ADDR_CTRL_CHAN, 8'hFE);
        rd(ADDR_CTRL_CHAN, 8'h7C);
        apb(1'b0, 8'h18, 32'h0, {32'h0, 1'b1});
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            fm = 1'($random(seed));
            rf = (i % 3 == 0) ? 2'h0 : 2'(i % 3 + 1);
            ch = 5'h18 + 5'(i);
            // No sync margin at /2
            level = (i == 0) ? {10{fm}} : 10'($random(seed));
            wr(ADDR_CTRL_FMT, {fm, 3'(i), 2'h0, rf});
            wr(ADDR_IRQ, {6'h0, i != 7, 1'b0});
            wr(ADDR_CTRL_CHAN, {1'b0, ch, 2'h1});
            if (i == 0) begin
                special_trig <= 1'b1;
                repeat (4) @(posedge ref_clk);
                special_trig <= 1'b0;
            end else wr(ADDR_CTRL_CHAN, {1'b0, ch, 2'h3});
            if (i % 4 == 3) wr(ADDR_SYS, 8'h01);
            wait_end(i != 7, n);
            @(posedge ref_clk);
            chk(pos_ref_sel, rf);
            chk(input_channel_sel, ch);
            if (hv[i] > 0) chk(n >= 21 * hv[i] && n <= 23 * hv[i] + 8, 1'b1);
            else chk(n > 5 && n < 400, 1'b1);
            if (i == 3) chk(wake_req, 1'b1);
            if (i == 7) chk(conv_irq, 1'b0);
            wr(ADDR_SYS, 8'h00);
            rd(ADDR_CTRL_CHAN, {1'b0, ch, 2'h1});
            rd(ADDR_IRQ, {6'h0, i != 7, 1'b1});
            rd(ADDR_RESULT_HIGH, fm ? {6'h0, level[9:8]} : level[9:2]);
            rd(ADDR_RESULT_LOW, fm ? level[7:0] : {level[1:0], 6'h0});
            wr(ADDR_IRQ, 8'h00);
            rd(ADDR_IRQ, 8'h00);
            $display("test select %0d done", i);
        end
        level = 10'h2AA;
        wr(ADDR_CTRL_FMT, {1'b1, CLK_DIV64, 4'h0});
        wr(ADDR_CTRL_CHAN, 8'h03);
        repeat (300) @(posedge ref_clk);
        wr(ADDR_CTRL_CHAN, 8'h01);
        rd(ADDR_RESULT_HIGH, 8'h02);
        rd(ADDR_RESULT_LOW, 8'hFF);
        wr(ADDR_CTRL_CHAN, 8'h03);
        wr(ADDR_SYS, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk(core_req.powered, 1'b0);
        rd(ADDR_CTRL_CHAN, 8'h01);
        wr(ADDR_SYS, 8'h00);
        wr(ADDR_CTRL_CHAN, 8'h03);
        repeat (20) @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(core_req.powered, 1'b0);
        rd(ADDR_CTRL_CHAN, 8'h00);
        rd(ADDR_CTRL_FMT, 8'h00);
        $display("test abort and reset done");
        end_of_test();
    end
endmodule : tb_top
